// ---- hw/flash_program_erase_control.sv ----
// Flash program and erase control: mode gating, registers, array access
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"
module flash_program_erase_control (
    input  wire logic                     clk_sys_i,
    input  wire logic                     nrst_i,
    input  wire logic                     hw_standby_i,
    input  wire logic                     sw_standby_i,
    input  wire logic                     hardware_write_permit_i,
    input  wire logic                     mode_select_pin_high_i,
    input  wire logic                     mode_select_pin_mid_i,
    input  wire logic                     mode_select_pin_low_i,
    input  wire flash_ctrl_pkg::cpu_req_s cpu_req_i,
    output logic                          rom_enabled_o,
    output logic [15:0]                   rdata_o,
    output logic                          rvalid_o,
    output logic [2:0]                    flash_mode_o,
    output logic                          array_prog_o,
    output logic                          array_erase_o,
    output logic [7:0]                    erase_blocks_o
);
    ////////////////////////////////////////////////////////////////////
    // Decode and state
    logic [7:0]  fmc_reg;
    logic [7:0]  ebs_reg;
    logic [7:0]  roc_reg;
    logic [7:0]  fmc_next;
    logic        rd_pend_reg;
    logic        rd_reg_sel_reg;
    logic        rd_hi_reg;
    logic        rd_byte_reg;
    logic [7:0]  reg_rdata_reg;
    logic [15:0] mem_rdata;
    flash_ctrl_pkg::flash_mode_e mode_now;

    function automatic logic hit(input logic [19:0] a, input logic [19:0] o);
        hit = (a == o);
    endfunction : hit

    wire [2:0] mode_pins = {mode_select_pin_high_i, mode_select_pin_mid_i,
                            mode_select_pin_low_i};
    wire rom_on   = (mode_pins == `MODE_ROM_ON);
    wire init_now = !nrst_i || hw_standby_i || sw_standby_i;
    wire [7:0] fmc_init = hardware_write_permit_i ?
                          `FMC_RESET_HIGH : `FMC_RESET_LOW;
    wire in_flash = rom_on && (cpu_req_i.addr <= `FLASH_TOP_ADDR);
    wire sel_fmc  = hit(cpu_req_i.addr, `FMC_OFFSET);
    wire sel_fes  = hit(cpu_req_i.addr, `FES_OFFSET);
    wire sel_ebs  = hit(cpu_req_i.addr, `EBS_OFFSET);
    wire sel_roc  = hit(cpu_req_i.addr, `ROC_OFFSET);
    wire sel_reg  = sel_fmc || sel_fes || sel_ebs || sel_roc;
    wire [7:0] wb = cpu_req_i.wdata[7:0];
    wire fmc_wr   = cpu_req_i.wr && sel_fmc && rom_on;
    wire hardware_write_permit      = hardware_write_permit_i;
    wire soft_write_enable      = fmc_reg[`BIT_SWE];
    wire lock_ok  = hardware_write_permit && soft_write_enable;
    wire erun_ok  = lock_ok && fmc_reg[`BIT_ESU];
    wire prun_ok  = lock_ok && fmc_reg[`BIT_PSU];

    ////////////////////////////////////////////////////////////////////
    // Gated next value of the mode control register
    always_comb begin
        fmc_next = fmc_reg;
        fmc_next[`BIT_PERMIT] = hardware_write_permit;
        if (fmc_wr) begin
            if (hardware_write_permit) fmc_next[`BIT_SWE] = wb[`BIT_SWE];
            if (lock_ok) begin
                fmc_next[`BIT_ESU] = wb[`BIT_ESU];
                fmc_next[`BIT_PSU] = wb[`BIT_PSU];
                fmc_next[`BIT_EV]  = wb[`BIT_EV];
                fmc_next[`BIT_PV]  = wb[`BIT_PV];
            end
            if (erun_ok) fmc_next[`BIT_ERUN] = wb[`BIT_ERUN];
            if (prun_ok) fmc_next[`BIT_PRUN] = wb[`BIT_PRUN];
        end
        // Dropping the permit pin takes away every write permission except ROC register writes
        if (!hardware_write_permit) fmc_next[6:0] = 7'h00;
    end

    // Operating mode from the register, in sequence order
    assign mode_now =
        (hardware_write_permit && soft_write_enable && fmc_reg[`BIT_PSU] && fmc_reg[`BIT_PRUN]) ?
            flash_ctrl_pkg::FM_PROG :
        (hardware_write_permit && soft_write_enable && fmc_reg[`BIT_ESU] && fmc_reg[`BIT_ERUN]) ?
            flash_ctrl_pkg::FM_ERASE :
        (soft_write_enable && fmc_reg[`BIT_PV]) ? flash_ctrl_pkg::FM_PVERIFY :
        (soft_write_enable && fmc_reg[`BIT_EV]) ? flash_ctrl_pkg::FM_EVERIFY :
            flash_ctrl_pkg::FM_READ;

    ////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk_sys_i) begin
        if (init_now) begin
            fmc_reg <= fmc_init;
            ebs_reg <= `EBS_RESET;
            roc_reg <= `ROC_RESET;
        end else begin
            fmc_reg <= fmc_next;
            // Block selects need soft enable; any mix allowed
            if (cpu_req_i.wr && sel_ebs && rom_on && lock_ok)
                ebs_reg <= wb;
            if (cpu_req_i.wr && sel_roc && rom_on)
                roc_reg <= wb;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Array access: reads and byte or word programming writes in program mode
    wire arr_rd = cpu_req_i.rd && in_flash;
    wire arr_wr = cpu_req_i.wr && in_flash &&
                  (mode_now == flash_ctrl_pkg::FM_PROG);
    wire [1:0] wmask = cpu_req_i.byte_acc ?
        (cpu_req_i.addr[0] ? 2'h1 : 2'h2) : 2'h3;
    wire [15:0] wdat = cpu_req_i.byte_acc ? {wb, wb} : cpu_req_i.wdata;

    flash_array_mem flash_array_mem_inst (
        .clk_sys_i (clk_sys_i),
        .rd_i      (arr_rd),
        .wr_i      (arr_wr),
        .addr_i    (cpu_req_i.addr[`FLASH_AW:1]),
        .wdata_i   (wdat),
        .wmask_i   (wmask),
        .rdata_o   (mem_rdata)
    );

    // Register read data; flash off returns zero for control
    wire [7:0] reg_rd =
        !rom_on ? 8'h00 :
        sel_fmc ? fmc_reg :
        sel_fes ? `FES_RESET :
        sel_ebs ? ebs_reg :
        sel_roc ? roc_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Read pipeline: request state, then answer state
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rd_pend_reg    <= 1'b0;
            rd_reg_sel_reg <= 1'b0;
            rd_hi_reg      <= 1'b0;
            rd_byte_reg    <= 1'b0;
            reg_rdata_reg  <= 8'h00;
        end else begin
            rd_pend_reg    <= cpu_req_i.rd && (in_flash || sel_reg);
            rd_reg_sel_reg <= sel_reg && !in_flash;
            rd_hi_reg      <= !cpu_req_i.addr[0];
            rd_byte_reg    <= cpu_req_i.byte_acc;
            reg_rdata_reg  <= reg_rd;
        end
    end

    wire [7:0] byte_pick = rd_hi_reg ? mem_rdata[15:8] : mem_rdata[7:0];
    wire [15:0] rd_mux = rd_reg_sel_reg ? {8'h00, reg_rdata_reg} :
                         rd_byte_reg ? {8'h00, byte_pick} : mem_rdata;

    ////////////////////////////////////////////////////////////////////
    // Output registers
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rom_enabled_o  <= 1'b0;
            rdata_o        <= 16'h0000;
            rvalid_o       <= 1'b0;
            flash_mode_o   <= 3'h0;
            array_prog_o   <= 1'b0;
            array_erase_o  <= 1'b0;
            erase_blocks_o <= 8'h00;
        end else begin
            rom_enabled_o  <= rom_on;
            rvalid_o       <= rd_pend_reg;
            rdata_o        <= rd_pend_reg ? rd_mux : rdata_o;
            flash_mode_o   <= mode_now;
            array_prog_o   <= (mode_now == flash_ctrl_pkg::FM_PROG);
            array_erase_o  <= (mode_now == flash_ctrl_pkg::FM_ERASE);
            erase_blocks_o <= ebs_reg;
        end
    end
endmodule : flash_program_erase_control
`default_nettype wire

// ---- hw/flash_ctrl_defines.svh ----
// Constants for the flash program and erase control block
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

`define FMC_OFFSET      20'hEE030
`define FES_OFFSET      20'hEE031
`define EBS_OFFSET      20'hEE032
`define ROC_OFFSET      20'hEE077
`define FMC_RESET_LOW   8'h00
`define FMC_RESET_HIGH  8'h80
`define FES_RESET       8'h00
`define EBS_RESET       8'h00
`define ROC_RESET       8'hF1
`define BIT_PERMIT      7
`define BIT_SWE         6
`define BIT_ESU         5
`define BIT_PSU         4
`define BIT_EV          3
`define BIT_PV          2
`define BIT_ERUN        1
`define BIT_PRUN        0
`define FLASH_TOP_ADDR  20'h1FFFF
`define PROG_UNIT_BYTES 128
`define MODE_ROM_ON     3'h5
`define FLASH_WORDS     65536
`define FLASH_AW        16

`endif

// ---- hw/flash_ctrl_pkg.sv ----
// Types for the flash program and erase control block
package flash_ctrl_pkg;
    typedef enum logic [2:0] {
        FM_READ, FM_PROG, FM_ERASE, FM_PVERIFY, FM_EVERIFY
    } flash_mode_e;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        byte_acc;
        logic [19:0] addr;
        logic [15:0] wdata;
    } cpu_req_s;
endpackage : flash_ctrl_pkg

// ---- hw/flash_array_mem.sv ----
// Flash array storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.svh"
module flash_array_mem (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rd_i,
    input  wire logic                   wr_i,
    input  wire logic [`FLASH_AW-1:0]   addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic [1:0]             wmask_i,
    output logic      [15:0]            rdata_o
);
    logic [15:0] mem [0:`FLASH_WORDS-1];

    // Registered read; programming only pulls bits low
    always_ff @(posedge clk_sys_i) begin
        if (rd_i) begin
            rdata_o <= mem[addr_i];
        end
        if (wr_i) begin
            if (wmask_i[1]) begin
                mem[addr_i][15:8] <= mem[addr_i][15:8] & wdata_i[15:8];
            end
            if (wmask_i[0]) begin
                mem[addr_i][7:0] <= mem[addr_i][7:0] & wdata_i[7:0];
            end
        end
    end
endmodule : flash_array_mem
`default_nettype wire

// ---- verification/cpu_bus_model.sv ----
// CPU core model issuing byte requests to the flash control block
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rvalid_i,
    input  wire logic [15:0]             rdata_i,
    output var  flash_ctrl_pkg::cpu_req_s req_o
);
    initial req_o = '0;
    // One byte request, released with inverted lines; answer taken where it stands
    task automatic xfer(input logic wr, input logic [19:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys_i);
        req_o <= '{wr, ~wr, 1'b1, a, {d, d}};
        @(posedge clk_sys_i);
        req_o <= '{1'b0, 1'b0, 1'b1, ~a, ~{d, d}};
        repeat (2) @(posedge clk_sys_i);
        q = rvalid_i ? rdata_i[7:0] : 8'hFF;
    endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

// ---- verification/flash_program_erase_control_checker.sv ----
// Port assertions for the flash program and erase control block
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_checker (
    input wire logic                     clk_sys_i,
    input wire logic                     nrst_i,
    input wire logic                     hw_standby_i,
    input wire logic                     sw_standby_i,
    input wire logic                     hardware_write_permit_i,
    input wire logic                     mode_select_pin_high_i,
    input wire logic                     mode_select_pin_mid_i,
    input wire logic                     mode_select_pin_low_i,
    input wire flash_ctrl_pkg::cpu_req_s cpu_req_i,
    input wire logic                     rom_enabled_o,
    input wire logic [15:0]              rdata_o,
    input wire logic                     rvalid_o,
    input wire logic [2:0]               flash_mode_o,
    input wire logic                     array_prog_o,
    input wire logic                     array_erase_o,
    input wire logic [7:0]               erase_blocks_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // Control register read, and a standby held two cycles
    sequence s_rd_ctrl;
        cpu_req_i.rd && cpu_req_i.addr == 20'hEE030;
    endsequence
    sequence s_standby;
        (hw_standby_i || sw_standby_i) [*2];
    endsequence
    a_rom_mode_five:
    assert property ($past(nrst_i) |-> rom_enabled_o == ($past({
        mode_select_pin_high_i, mode_select_pin_mid_i,
        mode_select_pin_low_i}) == 3'h5)) else $error("rom enable wrong");
    a_read_two_states:
    assert property (cpu_req_i.rd |-> ##2 rvalid_o) else $error("no rvalid");
    a_rvalid_cause:
    assert property (rvalid_o |-> $past(cpu_req_i.rd, 2))
        else $error("stray rvalid");
    a_prog_needs_permit:
    assert property (array_prog_o |-> $past(hardware_write_permit_i, 2))
        else $error("program without permit");
    a_erase_needs_permit:
    assert property (array_erase_o |-> $past(hardware_write_permit_i, 2))
        else $error("erase without permit");
    a_mode_needs_permit:
    assert property (flash_mode_o != 3'h0 |->
        $past(hardware_write_permit_i, 2)) else $error("mode without permit");
    a_standby_clears:
    assert property (s_standby |=> flash_mode_o == 3'h0 && !array_prog_o
        && !array_erase_o && erase_blocks_o == 8'h00)
        else $error("standby left state");
    a_disabled_reads_zero:
    assert property (s_rd_ctrl ##0 !rom_enabled_o |-> ##2
        rdata_o[7:0] == 8'h00) else $error("disabled read not zero");
endmodule : flash_program_erase_control_checker
bind flash_program_erase_control flash_program_erase_control_checker
    flash_program_erase_control_checker_inst (.*);
`default_nettype wire

// ---- verification/flash_program_erase_control_tb.sv ----
// Self-checking bench for the flash program and erase control block
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_tb;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, hardware_write_permit_i = 1'b1;
    logic hw_standby_i = 1'b0, sw_standby_i = 1'b0;
    logic mode_select_pin_high_i = 1'b1, mode_select_pin_mid_i = 1'b0;
    logic mode_select_pin_low_i = 1'b1;
    logic rom_enabled_o, rvalid_o, array_prog_o, array_erase_o;
    logic [15:0] rdata_o;
    logic [2:0]  flash_mode_o;
    logic [7:0]  erase_blocks_o, q;
    flash_ctrl_pkg::cpu_req_s cpu_req_i;
    int n_errors = 0;
    int check_count = 0;
    localparam logic [19:0] FMC = 20'hEE030;
    localparam logic [19:0] EBS = 20'hEE032;
    always #50 clk_sys_i = ~clk_sys_i;
    flash_program_erase_control flash_program_erase_control_inst (.*);
    cpu_bus_model cpu_bus_model_inst (.clk_sys_i(clk_sys_i),
        .rvalid_i(rvalid_o), .rdata_i(rdata_o), .req_o(cpu_req_i));
    ////////////////////////////////////////////////////////////////////
    // Shared compare and bus tasks
    task automatic cmp(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        cpu_bus_model_inst.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        cpu_bus_model_inst.xfer(1'b0, a, 8'h00, q);
        cmp($sformatf("reg %h", a), e, q);
    endtask : rd
    task automatic pulse_reset;
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
    endtask : pulse_reset
    task automatic set_mode(input logic [2:0] m);
        @(posedge clk_sys_i);
        {mode_select_pin_high_i, mode_select_pin_mid_i,
         mode_select_pin_low_i} <= m;
        if (m == 3'h6) hardware_write_permit_i <= 1'b0;
    endtask : set_mode
    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_values;
        repeat (2) @(posedge clk_sys_i);
        cmp("rom on", 8'h01, {7'h0, rom_enabled_o});
        rd(FMC, 8'h80);
        rd(20'hEE031, 8'h00);
        rd(EBS, 8'h00);
        rd(20'hEE077, 8'hF1);
        wr(FMC, 8'h10);
        rd(FMC, 8'h80);
        wr(FMC, 8'h00);
        rd(FMC, 8'h80);
    endtask : t_reset_values
    task automatic t_sequences;
        wr(FMC, 8'h40);
        wr(FMC, 8'h41);
        wr(FMC, 8'h42);
        rd(FMC, 8'hC0);
        wr(FMC, 8'h50);
        wr(FMC, 8'h51);
        rd(FMC, 8'hD1);
        cmp("prog", 8'h01, {7'h0, array_prog_o});
        cmp("mode", 8'h01, {5'h0, flash_mode_o});
        wr(20'h00001, 8'h00);
        wr(FMC, 8'h40);
        wr(FMC, 8'h00);
        rd(20'h00001, 8'h00);
        wr(FMC, 8'h40);
        wr(FMC, 8'h60);
        wr(FMC, 8'h62);
        cmp("erase", 8'h01, {7'h0, array_erase_o});
        cmp("mode", 8'h02, {5'h0, flash_mode_o});
        wr(FMC, 8'h40);
        wr(FMC, 8'h44);
        cmp("mode", 8'h03, {5'h0, flash_mode_o});
        wr(FMC, 8'h40);
        wr(FMC, 8'h48);
        cmp("mode", 8'h04, {5'h0, flash_mode_o});
        wr(EBS, 8'h01);
        cmp("blocks", 8'h01, erase_blocks_o);
    endtask : t_sequences
    task automatic t_standby(input logic hw);
        wr(FMC, 8'h40);
        wr(EBS, 8'h01);
        if (!hw) wr(FMC, 8'h00);
        @(posedge clk_sys_i);
        hw_standby_i <= hw;
        sw_standby_i <= !hw;
        repeat (3) @(posedge clk_sys_i);
        hw_standby_i <= 1'b0;
        sw_standby_i <= 1'b0;
        rd(FMC, 8'h80);
        rd(EBS, 8'h00);
    endtask : t_standby
    task automatic t_disabled;
        set_mode(3'h1);
        wr(FMC, 8'h40);
        cmp("rom on", 8'h00, {7'h0, rom_enabled_o});
        rd(FMC, 8'h00);
        set_mode(3'h5);
        rd(FMC, 8'h80);
    endtask : t_disabled
    task automatic t_protect;
        wr(FMC, 8'h40);
        @(posedge clk_sys_i);
        hardware_write_permit_i <= 1'b0;
        rd(FMC, 8'h00);
        wr(FMC, 8'h40);
        rd(FMC, 8'h00);
        pulse_reset();
        rd(FMC, 8'h00);
        set_mode(3'h6);
        rd(FMC, 8'h00);
        cmp("rom on", 8'h00, {7'h0, rom_enabled_o});
    endtask : t_protect
    task automatic print_verdict;
        if (n_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        pulse_reset();
        t_reset_values();
        t_sequences();
        t_standby(1'b1);
        t_standby(1'b0);
        t_disabled();
        t_protect();
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge clk_sys_i);
        n_errors++;
        print_verdict();
    end
endmodule : flash_program_erase_control_tb
`default_nettype wire
